// File: hw/dual_half_timer_core.sv
`timescale 1ns/100ps
`include "timer_params.svh"

// Notes on behaviour
// RL1: Reset sets both counts and both loads to all-ones, block idle, controls default.
// RL2: Reset clears both prescale registers to zero.
// RL3: Config 0 joins halves as timer; config 1 joins them as real-time counter.
// RL4: Config 4 splits the halves; each has its own mode.
// RL5: Joined load write: low half to A load, high half to B load.
// RL6: Joined read of A count gives B count above A count.
// RL7: Joined timer counts down 32 bits; only A mode picks one-shot or periodic.
// RL8: Count down, reload after zero; one-shot stops and clears enable.
// RL9: Time-out sets sticky raw flag until cleared; masked flag follows mask.
// RL10: Converter trigger pulses at time-out only with trigger enable set.
// RL11: Load write while running goes into the counter next clock.
// RL12: Stall bit plus debug halt freezes the count; resume afterwards.
// RL13: Real-time mode counts up; first selection loads one.
// RL14: Slow capture-pin clock is divided to one hertz to step the counter.
// RL15: Real-time count equal to match rolls over to zero and continues.
// RL16: Match sets raw flag, masked flag if unmasked; clear bit clears both.
// RL17: Real-time enable keeps counting through debug halt despite stall bits.
// RL18: Split halves are 16-bit down-counters with optional 8-bit prescale.
// RL19: Split half at zero reloads load and prescale; one-shot stops.
// RL20: Split half time-out sets its flags and trigger when enabled.
// RL21: Prescale value N gives N+1 clocks per count.
// RL22: Software clears a flag by writing one to its clear bit.
// RL23: Clear bits written zero leave the flags untouched.
module dual_half_timer_core #(
	parameter int RTC_DIV = `RTC_IN_HZ / `RTC_OUT_HZ
) (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic cfg_wr, // Write config_select_reg
	input wire logic [2:0] cfg_wdata, // Config value
	input wire logic mode_a_wr, // Write half_a_mode_reg
	input wire logic mode_b_wr, // Write half_b_mode_reg
	input wire logic [1:0] mode_wdata, // Mode field value
	input wire logic ctl_wr, // Write timer_control_reg
	input wire timer_pkg::ctl_t ctl_wdata, // Control value
	input wire logic load_a_wr, // Write half_a_interval_load
	input wire logic load_b_wr, // Write half_b_interval_load
	input wire logic [31:0] load_wdata, // Load value
	input wire logic pre_a_wr, // Write half_a_prescale_reg
	input wire logic pre_b_wr, // Write half_b_prescale_reg
	input wire logic [7:0] pre_wdata, // Prescale value
	input wire logic match_wr, // Write half_a_match_reg
	input wire logic [31:0] match_wdata, // Match value
	input wire timer_pkg::irq_t irq_mask, // irq_mask_reg contents
	input wire timer_pkg::irq_t irq_clear, // irq_clear_reg write pulse
	input wire logic dbg_halt, // Processor halted by debugger
	input wire logic capture_compare_pin, // Slow real-time input clock
	output timer_pkg::ctl_t ctl_rd, // timer_control_reg readback
	output logic [2:0] cfg_rd, // config_select_reg readback
	output logic [31:0] count_a_rd, // half_a_count_reg readback
	output logic [15:0] count_b_rd, // half_b_count_reg readback
	output timer_pkg::irq_t raw_status, // raw_irq_status_reg
	output timer_pkg::irq_t masked_status, // masked_irq_status_reg
	output logic irq, // Interrupt request
	output logic adc_trig // Converter trigger pulse
);
	// ============================================
	// Registers
	timer_pkg::ctl_t ctl, next_ctl;
	timer_pkg::irq_t raw, next_raw;
	timer_pkg::cfg_mode_t mode;
	logic [2:0] cfg, next_cfg;
	logic [1:0] mode_a, next_mode_a, mode_b, next_mode_b;
	logic [15:0] load_a, next_load_a, load_b, next_load_b;
	logic [7:0] pre_a, next_pre_a, pre_b, next_pre_b;
	logic [31:0] match, next_match;
	logic trig, next_trig;
	localparam logic [31:0] RTC_FIRST_VAL = `RTC_FIRST;

	// ============================================
	// Counter control
	logic [15:0] cnt_a, cnt_b;
	logic [31:0] full;
	logic tick_a, tick_b, rtc_tick;
	logic step_a, step_b, ld_a, ld_b, use_pre, count_up;
	logic [15:0] ld_val_a, ld_val_b;
	logic [7:0] ld_pre_a, ld_pre_b;
	logic to_a, to_b, match_hit, rtc_first;
	logic run_a, run_b, rtc_run;

	assign full = {cnt_b, cnt_a};

	always_comb begin
		case (cfg)
			`CFG_JOINED: mode = timer_pkg::joined_timer; // RL3
			`CFG_RTC: mode = timer_pkg::joined_rtc; // RL3
			default: mode = timer_pkg::split_halves; // RL4
		endcase
	end

	assign run_a = ctl.half_a_run_enable && !(dbg_halt && ctl.half_a_debug_stall); // RL12
	assign run_b = ctl.half_b_run_enable && !(dbg_halt && ctl.half_b_debug_stall); // RL12
	// Real-time enable overrides both stall bits during a halt
	assign rtc_run = ctl.half_a_run_enable && !(dbg_halt && !ctl.rtc_count_enable
		&& (ctl.half_a_debug_stall || ctl.half_b_debug_stall)); // RL17
	assign rtc_first = cfg_wr && cfg_wdata == `CFG_RTC && cfg != `CFG_RTC; // RL13

	always_comb begin
		step_a = 1'b0;
		step_b = 1'b0;
		ld_a = 1'b0;
		ld_b = 1'b0;
		ld_val_a = load_a;
		ld_val_b = load_b;
		ld_pre_a = `PRE_ZERO;
		ld_pre_b = `PRE_ZERO;
		use_pre = 1'b0;
		count_up = 1'b0;
		to_a = 1'b0;
		to_b = 1'b0;
		match_hit = 1'b0;
		case (mode)
			timer_pkg::joined_timer: begin
				// 32-bit down count; B borrows from A
				step_a = run_a;
				to_a = run_a && full == `FULL_ZERO; // RL8
				step_b = tick_a && cnt_a == `HALF_ZERO && !to_a; // RL7
				ld_a = to_a || load_a_wr; // RL8 RL11
				ld_b = ld_a;
				if (load_a_wr) begin
					ld_val_a = load_wdata[15:0]; // RL5 RL11
					ld_val_b = load_wdata[31:16]; // RL5 RL11
				end
			end
			timer_pkg::joined_rtc: begin
				count_up = 1'b1; // RL13
				step_a = rtc_run && rtc_tick; // RL14
				match_hit = step_a && full == match; // RL15
				step_b = tick_a && cnt_a == `HALF_ONES && !match_hit;
				ld_a = match_hit;
				ld_b = match_hit;
				ld_val_a = `HALF_ZERO; // RL15
				ld_val_b = `HALF_ZERO; // RL15
			end
			default: begin
				use_pre = 1'b1; // RL18
				step_a = run_a;
				step_b = run_b;
				to_a = tick_a && cnt_a == `HALF_ZERO; // RL19
				to_b = tick_b && cnt_b == `HALF_ZERO; // RL19
				ld_a = to_a || load_a_wr; // RL11 RL19
				ld_b = to_b || load_b_wr; // RL11 RL19
				ld_pre_a = pre_a; // RL19
				ld_pre_b = pre_b; // RL19
				if (load_a_wr) begin
					ld_val_a = load_wdata[15:0]; // RL11
				end
				if (load_b_wr) begin
					ld_val_b = load_wdata[15:0]; // RL11
				end
			end
		endcase
		if (rtc_first) begin
			ld_a = 1'b1;
			ld_b = 1'b1;
			ld_val_a = RTC_FIRST_VAL[15:0]; // RL13
			ld_val_b = RTC_FIRST_VAL[31:16]; // RL13
		end
	end

	half_counter u_half_a (
		.mclk(mclk),
		.rst(rst),
		.ld(ld_a),
		.ld_cnt(ld_val_a),
		.ld_pre(ld_pre_a),
		.step(step_a),
		.use_pre(use_pre),
		.count_up(count_up),
		.cnt(cnt_a),
		.tick(tick_a)
	);

	half_counter u_half_b (
		.mclk(mclk),
		.rst(rst),
		.ld(ld_b),
		.ld_cnt(ld_val_b),
		.ld_pre(ld_pre_b),
		.step(step_b),
		.use_pre(use_pre),
		.count_up(count_up),
		.cnt(cnt_b),
		.tick(tick_b)
	);

	rtc_prediv #(
		.DIV(RTC_DIV)
	) u_prediv (
		.mclk(mclk),
		.rst(rst),
		.en(mode == timer_pkg::joined_rtc),
		.pin(capture_compare_pin),
		.tick(rtc_tick)
	);

	// ============================================
	// Register file next values
	always_comb begin
		next_cfg = cfg_wr ? cfg_wdata : cfg;
		next_mode_a = mode_a_wr ? mode_wdata : mode_a;
		next_mode_b = mode_b_wr ? mode_wdata : mode_b;
		next_pre_a = pre_a_wr ? pre_wdata : pre_a;
		next_pre_b = pre_b_wr ? pre_wdata : pre_b;
		next_match = match_wr ? match_wdata : match;
		next_load_a = load_a_wr ? load_wdata[15:0] : load_a; // RL5
		next_load_b = load_b;
		if (load_a_wr && mode != timer_pkg::split_halves) begin
			next_load_b = load_wdata[31:16]; // RL5
		end else if (load_b_wr) begin
			next_load_b = load_wdata[15:0];
		end
		next_ctl = ctl;
		// Hardware clear first so a same-cycle software write wins
		if (to_a && mode_a == `MODE_ONESHOT) begin
			next_ctl.half_a_run_enable = 1'b0; // RL7 RL8 RL19
		end
		if (to_b && mode_b == `MODE_ONESHOT) begin
			next_ctl.half_b_run_enable = 1'b0; // RL19
		end
		if (ctl_wr) begin
			next_ctl = ctl_wdata;
		end
		// Set wins over a clear arriving in the same cycle
		next_raw = (raw & ~irq_clear) // RL22 RL23
			| timer_pkg::irq_t'({match_hit, to_b, to_a}); // RL9 RL16 RL20
		next_trig = (to_a && ctl.half_a_adc_trig_en) || (to_b && ctl.half_b_adc_trig_en); // RL10 RL20
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg <= `CFG_RESET; // RL1
			mode_a <= `MODE_RESET;
			mode_b <= `MODE_RESET;
			ctl <= '0; // RL1
			load_a <= `LOAD_RESET; // RL1
			load_b <= `LOAD_RESET; // RL1
			pre_a <= `PRE_RESET; // RL2
			pre_b <= `PRE_RESET; // RL2
			match <= `MATCH_RESET;
			raw <= '0;
			trig <= 1'b0;
		end else begin
			cfg <= next_cfg;
			mode_a <= next_mode_a;
			mode_b <= next_mode_b;
			ctl <= next_ctl;
			load_a <= next_load_a;
			load_b <= next_load_b;
			pre_a <= next_pre_a;
			pre_b <= next_pre_b;
			match <= next_match;
			raw <= next_raw;
			trig <= next_trig;
		end
	end

	// ============================================
	// Outputs
	assign ctl_rd = ctl;
	assign cfg_rd = cfg;
	assign count_a_rd = (mode == timer_pkg::split_halves) ? {`HALF_ZERO, cnt_a} : full; // RL6
	assign count_b_rd = cnt_b;
	assign raw_status = raw;
	assign masked_status = raw & irq_mask; // RL9 RL16 RL20
	assign irq = |masked_status; // RL16 RL20
	assign adc_trig = trig;

	// ============================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_split_timeout;
		mode == timer_pkg::split_halves && to_a && !load_a_wr && !cfg_wr;
	endsequence

	sequence s_reloaded;
		cnt_a == $past(load_a) && raw.half_a_timeout;
	endsequence

	a_reset_counts: assert property ($past(rst) |-> cnt_a == `CNT_RESET // RL1
		&& cnt_b == `CNT_RESET && load_a == `LOAD_RESET && !ctl.half_a_run_enable)
		else $error("counts or loads wrong after reset");
	a_reset_prescale: assert property ($past(rst) |-> pre_a == `PRE_ZERO // RL2
		&& pre_b == `PRE_ZERO)
		else $error("prescale not cleared by reset");
	a_split_reload: assert property (s_split_timeout |=> s_reloaded) // RL19
		else $error("split half did not reload or flag");
	a_oneshot_stop: assert property (to_a && mode_a == `MODE_ONESHOT && !ctl_wr // RL8
		|=> !ctl.half_a_run_enable)
		else $error("one-shot did not clear enable");
	a_joined_read: assert property (cfg == `CFG_JOINED |-> count_a_rd[31:16] == cnt_b) // RL6
		else $error("joined read word order wrong");
	a_flag_hold: assert property (raw.half_a_timeout && !irq_clear.half_a_timeout // RL9
		|=> raw.half_a_timeout)
		else $error("time-out flag lost without clear");
	a_trig_gate: assert property (adc_trig |-> $past(ctl.half_a_adc_trig_en) // RL10
		|| $past(ctl.half_b_adc_trig_en))
		else $error("trigger without trigger enable");
	a_stall_freeze: assert property (mode == timer_pkg::split_halves && dbg_halt // RL12
		&& ctl.half_a_debug_stall && !load_a_wr && !cfg_wr |=> $stable(cnt_a))
		else $error("count moved during stall");
	a_load_take: assert property (load_a_wr && cfg == `CFG_JOINED && !cfg_wr // RL11
		|=> full == $past(load_wdata))
		else $error("load write not taken next clock");
	a_rtc_first: assert property (rtc_first |=> full == `RTC_FIRST) // RL13
		else $error("first real-time selection not loaded with one");
	a_rtc_roll: assert property (match_hit && !cfg_wr |=> full == `FULL_ZERO // RL15
		&& raw.rtc_match)
		else $error("no roll over at match");
	a_rtc_nostall: assert property (mode == timer_pkg::joined_rtc && rtc_tick // RL17
		&& ctl.half_a_run_enable && ctl.rtc_count_enable && !match_hit && !cfg_wr
		|=> full == $past(full) + 32'h00000001)
		else $error("real-time count frozen");
	a_clear_works: assert property (irq_clear.rtc_match && !match_hit // RL16
		|=> !raw.rtc_match && !masked_status.rtc_match)
		else $error("match clear ineffective");
endmodule

// File: hw/half_counter.sv
`timescale 1ns/100ps
`include "timer_params.svh"

module half_counter (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic ld, // Load count and prescale
	input wire logic [15:0] ld_cnt, // Count load value
	input wire logic [7:0] ld_pre, // Prescale load value
	input wire logic step, // Counting allowed this cycle
	input wire logic use_pre, // Prescaler in use
	input wire logic count_up, // Count direction
	output logic [15:0] cnt, // Current count
	output logic tick // Count changes this cycle
);
	logic [7:0] pre;
	logic [15:0] next_cnt;
	logic [7:0] next_pre;

	assign tick = step && (!use_pre || pre == `PRE_ZERO); // RL21

	always_comb begin
		next_cnt = cnt;
		next_pre = pre;
		if (ld) begin
			next_cnt = ld_cnt;
			next_pre = ld_pre;
		end else if (step) begin
			if (tick) begin
				next_pre = ld_pre; // RL21
				next_cnt = count_up ? cnt + 16'h0001 : cnt - 16'h0001;
			end else begin
				next_pre = pre - 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt <= `CNT_RESET; // RL1
			pre <= `PRE_RESET; // RL2
		end else begin
			cnt <= next_cnt;
			pre <= next_pre;
		end
	end
endmodule

// File: hw/rtc_prediv.sv
`timescale 1ns/100ps
`include "timer_params.svh"

module rtc_prediv #(
	parameter int DIV = `RTC_IN_HZ / `RTC_OUT_HZ
) (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic en, // Divider active
	input wire logic pin, // Slow clock from capture pin
	output logic tick // One-cycle pulse per divided period
);
	localparam int W = $clog2(DIV + 1);

	logic sync1;
	logic sync2;
	logic prev;
	logic rise;
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	// Pin is asynchronous; edge taken only after two stages
	assign rise = sync2 && !prev;
	assign tick = en && rise && cnt == W'(DIV - 1); // RL14

	always_comb begin
		next_cnt = cnt;
		if (!en) begin
			next_cnt = '0;
		end else if (rise) begin
			next_cnt = (cnt == W'(DIV - 1)) ? '0 : cnt + W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev <= 1'b0;
			cnt <= '0;
		end else begin
			sync1 <= pin;
			sync2 <= sync1;
			prev <= sync2;
			cnt <= next_cnt;
		end
	end
endmodule

// File: hw/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ============================================
// Configuration select codes
`define CFG_JOINED 3'h0
`define CFG_RTC 3'h1
`define CFG_SPLIT 3'h4
`define CFG_RESET 3'h0

// ============================================
// Half mode field codes
`define MODE_ONESHOT 2'h1
`define MODE_PERIODIC 2'h2
`define MODE_RESET 2'h0

// ============================================
// Reset and special values
`define LOAD_RESET 16'hffff
`define CNT_RESET 16'hffff
`define PRE_RESET 8'h00
`define PRE_ZERO 8'h00
`define HALF_ZERO 16'h0000
`define HALF_ONES 16'hffff
`define FULL_ZERO 32'h00000000
`define RTC_FIRST 32'h00000001
`define MATCH_RESET 32'hffffffff

// ============================================
// Real-time input and output rates in Hz
`define RTC_IN_HZ 32768
`define RTC_OUT_HZ 1

`endif

// File: hw/timer_pkg.sv
package timer_pkg;

	typedef enum logic [1:0] {
		joined_timer,
		joined_rtc,
		split_halves
	} cfg_mode_t;

	// Control bits; the two run enables may be cleared by hardware
	typedef struct packed {
		logic rtc_count_enable;
		logic half_b_adc_trig_en;
		logic half_b_debug_stall;
		logic half_b_run_enable;
		logic half_a_adc_trig_en;
		logic half_a_debug_stall;
		logic half_a_run_enable;
	} ctl_t;

	// One bit per event source
	typedef struct packed {
		logic rtc_match;
		logic half_b_timeout;
		logic half_a_timeout;
	} irq_t;

endpackage

// File: tb/tb.sv
`timescale 1ns/100ps

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb;
	// ============================================
	// Stimulus and observed signals
	logic mclk, rst, cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_a_wr, load_b_wr;
	logic pre_a_wr, pre_b_wr, match_wr, dbg_halt, capture_compare_pin;
	logic [2:0] cfg_wdata, cfg_rd;
	logic [1:0] mode_wdata;
	logic [31:0] load_wdata, match_wdata, count_a_rd;
	logic [7:0] pre_wdata;
	logic [15:0] count_b_rd;
	logic irq, adc_trig;
	timer_pkg::ctl_t ctl_wdata, ctl_rd;
	timer_pkg::irq_t irq_mask, irq_clear, raw_status, masked_status;
	int miscompares = 0;
	int checked = 0;
	localparam int CFG = 0, MDA = 1, MDB = 2, CTL = 3, LDA = 4, LDB = 5, PRA = 6, PRB = 7, MAT = 8;

	// Short divider keeps the real-time steps within a short run
	dual_half_timer_core #(.RTC_DIV(4)) i_dut (.mclk(mclk), .rst(rst), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .mode_a_wr(mode_a_wr), .mode_b_wr(mode_b_wr),
		.mode_wdata(mode_wdata), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
		.load_a_wr(load_a_wr), .load_b_wr(load_b_wr), .load_wdata(load_wdata),
		.pre_a_wr(pre_a_wr), .pre_b_wr(pre_b_wr), .pre_wdata(pre_wdata),
		.match_wr(match_wr), .match_wdata(match_wdata), .irq_mask(irq_mask),
		.irq_clear(irq_clear), .dbg_halt(dbg_halt), .capture_compare_pin(capture_compare_pin),
		.ctl_rd(ctl_rd), .cfg_rd(cfg_rd), .count_a_rd(count_a_rd), .count_b_rd(count_b_rd),
		.raw_status(raw_status), .masked_status(masked_status), .irq(irq), .adc_trig(adc_trig));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ============================================
	// Shared drivers
	task automatic tally_and_finish;
		if (miscompares == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One-cycle strobe; the write is taken at the edge that lowers it
	task automatic wr(input int sel, input logic [31:0] v);
		@(posedge mclk);
		case (sel)
			CFG: begin cfg_wr <= 1'b1; cfg_wdata <= v[2:0]; end
			MDA: begin mode_a_wr <= 1'b1; mode_wdata <= v[1:0]; end
			MDB: begin mode_b_wr <= 1'b1; mode_wdata <= v[1:0]; end
			CTL: begin ctl_wr <= 1'b1; ctl_wdata <= timer_pkg::ctl_t'(v[6:0]); end
			LDA: begin load_a_wr <= 1'b1; load_wdata <= v; end
			LDB: begin load_b_wr <= 1'b1; load_wdata <= v; end
			PRA: begin pre_a_wr <= 1'b1; pre_wdata <= v[7:0]; end
			PRB: begin pre_b_wr <= 1'b1; pre_wdata <= v[7:0]; end
			default: begin match_wr <= 1'b1; match_wdata <= v; end
		endcase
		@(posedge mclk);
		{cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_a_wr} <= 5'h00;
		{load_b_wr, pre_a_wr, pre_b_wr, match_wr} <= 4'h0;
		irq_clear <= 3'h0;
		#1;
	endtask

	task automatic clr(input timer_pkg::irq_t v);
		@(posedge mclk);
		irq_clear <= v;
		@(posedge mclk);
		irq_clear <= 3'h0;
		#1;
	endtask

	// Edges until the raw flag rises, bounded
	task automatic wait_raw(input int b, input int exp_n, input string nm);
		int n;
		n = 0;
		while (raw_status[b] !== 1'b1) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 2000) begin
				miscompares++;
				tally_and_finish();
			end
		end
		`CHK(nm, exp_n, n)
	endtask

	// Slow clock: high four and low five system clocks per period
	task automatic pins(input int k);
		repeat (k) begin
			@(posedge mclk);
			capture_compare_pin <= 1'b1;
			repeat (4) @(posedge mclk);
			capture_compare_pin <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		#1;
	endtask

	// ============================================
	// Scenarios
	task automatic t_reset;
		`CHK("count_a", 32'hffffffff, count_a_rd)
		`CHK("count_b", 16'hffff, count_b_rd)
		`CHK("ctl", 7'h00, ctl_rd)
		`CHK("cfg", 3'h0, cfg_rd)
		`CHK("raw", 3'h0, raw_status)
		`CHK("trig", 1'b0, adc_trig)
	endtask

	task automatic t_split_oneshot;
		wr(CFG, 32'h4);
		`CHK("cfg", 3'h4, cfg_rd)
		wr(LDA, 32'h0003);
		`CHK("count_a", 32'h00000003, count_a_rd)
		wr(MDA, 32'h1);
		wr(CTL, 32'h05);
		wait_raw(0, 4, "oneshot_len");
		`CHK("trig", 1'b1, adc_trig)
		`CHK("run_a", 1'b0, ctl_rd.half_a_run_enable)
		`CHK("irq", 1'b0, irq)
		@(posedge mclk);
		#1;
		`CHK("trig_len", 1'b0, adc_trig)
		repeat (5) @(posedge mclk);
		#1;
		`CHK("count_a", 32'h00000003, count_a_rd)
		clr(3'b001);
		`CHK("raw", 3'h0, raw_status)
	endtask

	task automatic t_split_periodic;
		wr(PRB, 32'h02);
		wr(LDB, 32'h0004);
		wr(MDB, 32'h2);
		@(posedge mclk);
		irq_mask <= 3'b010;
		wr(CTL, 32'h08);
		wait_raw(1, 15, "prescale_len");
		`CHK("masked", 3'b010, masked_status)
		`CHK("irq", 1'b1, irq)
		`CHK("trig_off", 1'b0, adc_trig)
		clr(3'b000);
		`CHK("raw_keep", 1'b1, raw_status[1])
		clr(3'b010);
		`CHK("raw_clr", 1'b0, raw_status[1])
		`CHK("run_b", 1'b1, ctl_rd.half_b_run_enable)
		wait_raw(1, 11, "period_len");
		wr(CTL, 32'h00);
		clr(3'b010);
		@(posedge mclk);
		irq_mask <= 3'b000;
	endtask

	task automatic t_stall;
		logic [31:0] c;
		wr(LDA, 32'h0014);
		wr(MDA, 32'h2);
		wr(CTL, 32'h03);
		@(posedge mclk);
		dbg_halt <= 1'b1;
		@(posedge mclk);
		#1;
		c = count_a_rd;
		repeat (5) @(posedge mclk);
		#1;
		`CHK("frozen", c, count_a_rd)
		@(posedge mclk);
		dbg_halt <= 1'b0;
		@(posedge mclk);
		#1;
		`CHK("resumed", c - 32'h1, count_a_rd)
		wr(CTL, 32'h00);
	endtask

	task automatic t_joined;
		wr(CFG, 32'h0);
		wr(MDA, 32'h1);
		wr(MDB, 32'h2);
		wr(LDA, 32'h00010001);
		`CHK("count_a", 32'h00010001, count_a_rd)
		`CHK("count_b", 16'h0001, count_b_rd)
		@(posedge mclk);
		irq_mask <= 3'b001;
		wr(CTL, 32'h01);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("borrow", 32'h0000ffff, count_a_rd)
		wr(LDA, 32'h00000002);
		`CHK("reload", 32'h00000002, count_a_rd)
		wait_raw(0, 3, "joined_len");
		`CHK("run_a", 1'b0, ctl_rd.half_a_run_enable)
		`CHK("count_a", 32'h00000002, count_a_rd)
		`CHK("masked", 3'b001, masked_status)
		`CHK("irq", 1'b1, irq)
		clr(3'b001);
		@(posedge mclk);
		irq_mask <= 3'b000;
	endtask

	task automatic t_rtc;
		wr(CFG, 32'h1);
		`CHK("first", 32'h00000001, count_a_rd)
		wr(MAT, 32'h00000003);
		@(posedge mclk);
		irq_mask <= 3'b100;
		dbg_halt <= 1'b1;
		wr(CTL, 32'h53);
		pins(4);
		`CHK("rtc2", 32'h00000002, count_a_rd)
		pins(4);
		`CHK("rtc3", 32'h00000003, count_a_rd)
		pins(4);
		`CHK("rollover", 32'h00000000, count_a_rd)
		`CHK("raw_m", 1'b1, raw_status[2])
		`CHK("masked_m", 3'b100, masked_status)
		`CHK("irq", 1'b1, irq)
		pins(4);
		`CHK("rtc_on", 32'h00000001, count_a_rd)
		clr(3'b100);
		`CHK("masked_clr", 3'b000, masked_status)
		@(posedge mclk);
		dbg_halt <= 1'b0;
	endtask

	initial begin
		rst = 1'b1;
		{cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_a_wr, load_b_wr} = 6'h00;
		{pre_a_wr, pre_b_wr, match_wr, dbg_halt, capture_compare_pin} = 5'h00;
		cfg_wdata = 3'h0;
		mode_wdata = 2'h0;
		ctl_wdata = 7'h00;
		load_wdata = 32'h00000000;
		pre_wdata = 8'h00;
		match_wdata = 32'h00000000;
		irq_mask = 3'h0;
		irq_clear = 3'h0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		t_reset();
		t_split_oneshot();
		t_split_periodic();
		t_stall();
		t_joined();
		t_rtc();
		tally_and_finish();
	end
endmodule
